/* File: verilog/lfe_regs.sv */
// Second-link frequency, error, capability and scratchpad registers
// Functional notes
// - Receive overflow sets sticky flag bit 5; read clears; kept on warm reset
// - Protocol violation sets sticky flag bit 4; read clears; kept on warm reset
// - Each error flag routes to sync flood, fatal or nonfatal by enables
// - Rate field bits 3:0 picks 200, 300, 400, 500 or 600 MHz
// - Link data rate is twice the transmitter clock, both edges used
// - New rate code written by software takes effect at next warm reset
// - In synchronous clocking, receiver and transmitter both use programmed rate
// - Rate field clears only on cold reset, survives warm reset
// - Non-bridging modes read these registers as zero; plain dual mode does too
// - Single bridge uses primary set; dual bridge uses secondary space for frequency/error and capability, primary scratchpad
// - Read-only 16-bit capability vector, bit N marks code N supported
// - Capability is 0x0007, 0x000f or 0x001f for 100, 133, 200 MHz core
// - 16-bit scratchpad, reset zero, no hardware effect
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
module lfe_regs (
  // Clock and cold reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [10:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Straps and warm reset pins
  input  wire logic [1:0]  mode_i,
  input  wire logic [1:0]  core_clk_sel_i,
  input  wire logic        sync_clocking_i,
  input  wire logic        warm_rst_i,
  // Link side
  input  wire logic        link_clk_i,
  input  wire logic        link_ovf_i,
  input  wire logic        link_proto_i,
  // Rate and error outputs
  output logic      [3:0]  tx_rate_o,
  output logic      [3:0]  rx_rate_o,
  output logic      [10:0] data_rate_o,
  output logic             sync_flood_o,
  output logic             fatal_err_o,
  output logic             nonfatal_err_o
);

  // ******************************************************************
  // Link event sampling
  // ******************************************************************
  lfe_evt_if evt ();

  lfe_link_sampler u_sampler (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .link_clk_i   (link_clk_i),
    .link_ovf_i   (link_ovf_i),
    .link_proto_i (link_proto_i),
    .evt          (evt.src)
  );

  // ******************************************************************
  // Strap and warm reset synchronisers
  // ******************************************************************
  logic [5:0]        pin_s1_reg;
  logic [5:0]        pin_s2_reg;
  logic              warm_last_reg;
  lfe_pkg::lfe_mode_e mode_reg;
  logic [1:0]        core_sel_reg;
  logic              sync_clk_reg;
  wire  logic        warm_pulse;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_reg    <= 6'h00;
      pin_s2_reg    <= 6'h00;
      warm_last_reg <= 1'b0;
      mode_reg      <= lfe_pkg::LFE_PLAIN_SINGLE_MODE;
      core_sel_reg  <= lfe_pkg::CORE_100;
      sync_clk_reg  <= 1'b0;
    end
    else
    begin
      pin_s1_reg    <= {mode_i, core_clk_sel_i, sync_clocking_i, warm_rst_i};
      pin_s2_reg    <= pin_s1_reg;
      warm_last_reg <= pin_s2_reg[0];
      mode_reg      <= lfe_pkg::lfe_mode_e'(pin_s2_reg[5:4]);
      core_sel_reg  <= pin_s2_reg[3:2];
      sync_clk_reg  <= pin_s2_reg[1];
    end
  end

  assign warm_pulse = pin_s2_reg[0] & ~warm_last_reg;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  wire logic [8:0] idx       = wb_adr_i[10:2];
  wire logic       single_br = mode_reg == lfe_pkg::LFE_SINGLE_PORT_BRIDGE;
  wire logic       dual_br   = mode_reg == lfe_pkg::LFE_DUAL_PORT_BRIDGE;
  wire logic       bridge    = single_br | dual_br;
  wire logic       req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic       rd        = req & ~wb_we_i;
  wire logic       wr        = req & wb_we_i;
  // Primary frequency/error and capability serve single bridge only; dual uses secondary; scratch and routing stay primary in both
  wire logic hit_fe  = (single_br & idx == lfe_pkg::FREQ_ERR_IDX) |
                       (dual_br & idx == lfe_pkg::SEC_FREQ_ERR_IDX);
  wire logic hit_cap = (single_br & idx == lfe_pkg::CAP_IDX) |
                       (dual_br & idx == lfe_pkg::SEC_CAP_IDX);
  wire logic hit_scr = bridge & idx == lfe_pkg::SCRATCH_IDX;
  wire logic hit_rte = bridge & idx == lfe_pkg::ROUTE_IDX;
  wire logic hit_sts = idx == lfe_pkg::STATUS_IDX;

  // ******************************************************************
  // Register state
  // ******************************************************************
  logic        ovf_reg;
  logic        proto_reg;
  logic [3:0]  rate_sel_reg;
  logic [3:0]  active_rate_reg;
  logic [15:0] scratch_reg;
  logic [15:0] route_reg;
  logic [15:0] cap_vec;
  logic        ovf_next;
  logic        proto_next;

  // Flags are sticky; a simultaneous event beats the clearing read
  wire logic clr_fe    = rd & hit_fe;
  wire logic set_ovf   = bridge & evt.ovf_evt;
  wire logic set_proto = bridge & evt.proto_evt;
  assign ovf_next   = (ovf_reg & ~clr_fe) | set_ovf;
  assign proto_next = (proto_reg & ~clr_fe) | set_proto;

  // Capability follows the core clock strap
  assign cap_vec = (core_sel_reg == lfe_pkg::CORE_100) ? lfe_pkg::CAP_CORE_100 :
                   (core_sel_reg == lfe_pkg::CORE_133) ? lfe_pkg::CAP_CORE_133 :
                   lfe_pkg::CAP_CORE_200;

  // Only cold reset touches the flags and the rate field
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovf_reg      <= 1'b0;
      proto_reg    <= 1'b0;
      rate_sel_reg <= lfe_pkg::RATE_RESET;
      scratch_reg  <= lfe_pkg::SCRATCH_RESET;
    end
    else
    begin
      ovf_reg   <= ovf_next;
      proto_reg <= proto_next;
      if (wr & hit_fe & wb_sel_i[0])
        rate_sel_reg <= wb_dat_i[3:0];
      if (wr & hit_scr & wb_sel_i[0])
        scratch_reg[7:0] <= wb_dat_i[7:0];
      if (wr & hit_scr & wb_sel_i[1])
        scratch_reg[15:8] <= wb_dat_i[15:8];
    end
  end

  // Warm reset loads the new rate and clears the routing enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_rate_reg <= lfe_pkg::RATE_RESET;
      route_reg       <= lfe_pkg::ROUTE_RESET;
    end
    else if (warm_pulse)
    begin
      active_rate_reg <= rate_sel_reg;
      route_reg       <= lfe_pkg::ROUTE_RESET;
    end
    else
    begin
      if (wr & hit_rte & wb_sel_i[0])
        route_reg[7:0] <= wb_dat_i[7:0] & lfe_pkg::ROUTE_MASK[7:0];
      if (wr & hit_rte & wb_sel_i[1])
        route_reg[15:8] <= wb_dat_i[15:8] & lfe_pkg::ROUTE_MASK[15:8];
    end
  end

  // ******************************************************************
  // Read mux and bus answer
  // ******************************************************************
  wire logic [31:0] rd_fe  = {26'h0, ovf_reg, proto_reg, rate_sel_reg};
  wire logic [31:0] rd_sts = {24'h0, core_sel_reg, mode_reg, active_rate_reg};
  // Unmapped and reserved locations read zero
  wire logic [31:0] rd_mux = hit_fe  ? rd_fe :
                             hit_cap ? {16'h0, cap_vec} :
                             hit_scr ? {16'h0, scratch_reg} :
                             hit_rte ? {16'h0, route_reg} :
                             hit_sts ? rd_sts : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_mux : 32'h0;
    end
  end

  // ******************************************************************
  // Rate and error outputs
  // ******************************************************************
  wire logic [10:0] ddr_rate = {lfe_pkg::lfe_rate_mhz(active_rate_reg), 1'b0};
  wire logic flood = (ovf_reg & route_reg[lfe_pkg::ROUTE_FL_OVF]) |
                     (proto_reg & route_reg[lfe_pkg::ROUTE_FL_PROTO]);
  wire logic fatal = (ovf_reg & route_reg[lfe_pkg::ROUTE_FT_OVF]) |
                     (proto_reg & route_reg[lfe_pkg::ROUTE_FT_PROTO]);
  wire logic nfat  = (ovf_reg & route_reg[lfe_pkg::ROUTE_NF_OVF]) |
                     (proto_reg & route_reg[lfe_pkg::ROUTE_NF_PROTO]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_rate_o      <= lfe_pkg::RATE_RESET;
      rx_rate_o      <= lfe_pkg::RATE_RESET;
      data_rate_o    <= 11'h000;
      sync_flood_o   <= 1'b0;
      fatal_err_o    <= 1'b0;
      nonfatal_err_o <= 1'b0;
    end
    else
    begin
      tx_rate_o      <= active_rate_reg;
      rx_rate_o      <= sync_clk_reg ? active_rate_reg
                                     : lfe_pkg::RATE_RESET;
      data_rate_o    <= ddr_rate;
      sync_flood_o   <= flood;
      fatal_err_o    <= fatal;
      nonfatal_err_o <= nfat;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  chk_ovf_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    set_ovf |=> ovf_reg)
    else $error("overflow event did not set flag");

  chk_proto_sets_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    set_proto |=> proto_reg)
    else $error("protocol event did not set flag");

  chk_read_clears_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clr_fe && !set_ovf |=> !ovf_reg)
    else $error("read did not clear overflow flag");

  chk_set_beats_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clr_fe && set_proto |=> proto_reg ##1 (proto_reg || clr_fe))
    else $error("protocol event lost under clearing read");

  chk_rate_waits_warm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !warm_pulse |=> $stable(active_rate_reg))
    else $error("active rate changed without warm reset");

  chk_rate_on_warm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    warm_pulse |=> active_rate_reg == $past(rate_sel_reg) ##1
      tx_rate_o == $past(active_rate_reg))
    else $error("warm reset did not load programmed rate");

  chk_rate_cold_zero: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> rate_sel_reg == 4'h0 && ovf_reg == 1'b0)
    else $error("cold reset did not clear rate field");

  chk_cap_core_100: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && hit_cap && core_sel_reg == 2'h0 |=> wb_dat_o == 32'h0000_0007)
    else $error("capability wrong for 100 MHz core");

  chk_plain_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && !bridge && idx != lfe_pkg::STATUS_IDX |=> wb_dat_o == 32'h0)
    else $error("non-bridging mode read was not zero");

  chk_fatal_route: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ovf_reg && route_reg[3] |=> fatal_err_o)
    else $error("overflow not routed to fatal output");

  chk_data_rate_double: assert property (
    @(posedge clk_i) disable iff (rst_i)
    active_rate_reg == 4'h4 |=> data_rate_o == 11'd1200)
    else $error("data rate not twice the clock");

  chk_cap_core_200: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && hit_cap && core_sel_reg[1] |=> wb_dat_o == 32'h0000_001f)
    else $error("capability wrong for 200 MHz core");

  chk_plain_no_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !bridge && !ovf_reg && !proto_reg |=> !ovf_reg && !proto_reg)
    else $error("error flag set outside bridging modes");

endmodule : lfe_regs

/* File: verilog/lfe_pkg.sv */
// Constants and types shared by the link frequency and error register block
package lfe_pkg;

  // ******************************************************************
  // Register indices (byte address is four times the index)
  // ******************************************************************
  localparam logic [8:0] FREQ_ERR_IDX     = 9'h0_051;
  localparam logic [8:0] CAP_IDX          = 9'h0_052;
  localparam logic [8:0] SCRATCH_IDX      = 9'h0_054;
  localparam logic [8:0] ROUTE_IDX        = 9'h0_056;
  localparam logic [8:0] STATUS_IDX       = 9'h0_057;
  localparam logic [8:0] SEC_FREQ_ERR_IDX = 9'h0_10d;
  localparam logic [8:0] SEC_CAP_IDX      = 9'h0_10e;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int OVF_BIT         = 5;
  localparam int PROTO_BIT       = 4;
  localparam int ROUTE_NF_OVF    = 11;
  localparam int ROUTE_NF_PROTO  = 10;
  localparam int ROUTE_FT_OVF    = 3;
  localparam int ROUTE_FT_PROTO  = 2;
  localparam int ROUTE_FL_OVF    = 1;
  localparam int ROUTE_FL_PROTO  = 0;
  localparam logic [15:0] ROUTE_MASK = 16'h0_c0f;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [3:0]  RATE_RESET    = 4'h0;
  localparam logic [15:0] SCRATCH_RESET = 16'h0_000;
  localparam logic [15:0] ROUTE_RESET   = 16'h0_000;

  // ******************************************************************
  // Capability vectors by core clock
  // ******************************************************************
  localparam logic [15:0] CAP_CORE_100 = 16'h0_007;
  localparam logic [15:0] CAP_CORE_133 = 16'h0_00f;
  localparam logic [15:0] CAP_CORE_200 = 16'h0_01f;

  // ******************************************************************
  // Operating modes and core clock straps
  // ******************************************************************
  typedef enum logic [1:0] {
    LFE_PLAIN_SINGLE_MODE   = 2'b00,
    LFE_PLAIN_DUAL_MODE     = 2'b01,
    LFE_SINGLE_PORT_BRIDGE  = 2'b10,
    LFE_DUAL_PORT_BRIDGE    = 2'b11
  } lfe_mode_e;

  localparam logic [1:0] CORE_100 = 2'h0;
  localparam logic [1:0] CORE_133 = 2'h1;

  // Transmitter clock in MHz for a rate code, zero for reserved codes
  function automatic logic [9:0] lfe_rate_mhz(input logic [3:0] code);
    case (code)
      4'h0:    lfe_rate_mhz = 10'd200;
      4'h1:    lfe_rate_mhz = 10'd300;
      4'h2:    lfe_rate_mhz = 10'd400;
      4'h3:    lfe_rate_mhz = 10'd500;
      4'h4:    lfe_rate_mhz = 10'd600;
      default: lfe_rate_mhz = 10'd0;
    endcase
  endfunction : lfe_rate_mhz

endpackage : lfe_pkg

/* File: verilog/lfe_evt_if.sv */
// Event carrier between the link sampler and the register block
`timescale 1ns/10ps
interface lfe_evt_if;
  logic ovf_evt;
  logic proto_evt;
  logic link_edge;
  modport src (output ovf_evt, output proto_evt, output link_edge);
  modport dst (input ovf_evt, input proto_evt, input link_edge);
endinterface : lfe_evt_if

/* File: verilog/lfe_link_sampler.sv */
// Samples the link clock and error levels and turns them into event pulses
`timescale 1ns/10ps
module lfe_link_sampler (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link pins
  input  wire logic link_clk_i,
  input  wire logic link_ovf_i,
  input  wire logic link_proto_i,
  // Events
  lfe_evt_if.src    evt
);

  // ******************************************************************
  // Synchronisers
  // ******************************************************************
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic       clk_last_reg;
  wire  logic any_edge;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg       <= 3'h0;
      s2_reg       <= 3'h0;
      clk_last_reg <= 1'b0;
    end
    else
    begin
      s1_reg       <= {link_clk_i, link_ovf_i, link_proto_i};
      s2_reg       <= s1_reg;
      clk_last_reg <= s2_reg[2];
    end
  end

  // Data move on both link clock edges, so both are sampling points
  assign any_edge = s2_reg[2] ^ clk_last_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt.ovf_evt   <= 1'b0;
      evt.proto_evt <= 1'b0;
      evt.link_edge <= 1'b0;
    end
    else
    begin
      evt.ovf_evt   <= any_edge & s2_reg[1];
      evt.proto_evt <= any_edge & s2_reg[0];
      evt.link_edge <= any_edge;
    end
  end

endmodule : lfe_link_sampler

/* File: testbench/lfe_link_model.sv */
// Behavioural far-end link device driving clock and error levels
`timescale 1ns/10ps
module lfe_link_model (
  // Control from the bench
  input  wire logic run_i,
  input  wire logic ovf_req_i,
  input  wire logic proto_req_i,
  // Link pins
  output logic      link_clk_o,
  output logic      link_ovf_o,
  output logic      link_proto_o
);
  // ******************************************************************
  // Clock toggles only in bursts; levels move well clear of each edge
  // ******************************************************************
  initial
  begin
    link_clk_o   = 1'b0;
    link_ovf_o   = 1'b0;
    link_proto_o = 1'b0;
    #37;
    forever
    begin
      #180;
      if (run_i)
      begin
        link_ovf_o   = ovf_req_i;
        link_proto_o = proto_req_i;
      end
      #20;
      // A cut burst still ends on a falling edge so the clock rests low
      if (run_i || link_clk_o)
        link_clk_o = ~link_clk_o;
    end
  end
endmodule : lfe_link_model

/* File: testbench/tb.sv */
// Self-checking bench for the link rate and error register block
`timescale 1ns/10ps
module tb;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [10:0] wb_adr    = 11'h000;
  logic [31:0] wb_dat    = 32'h0;
  logic [1:0]  mode      = 2'b10;
  logic [1:0]  core_sel  = 2'b00;
  logic        sync_clk  = 1'b1;
  logic        warm_rst  = 1'b0;
  logic        run       = 1'b0;
  logic        ovf_req   = 1'b0;
  logic        proto_req = 1'b0;
  logic [31:0] wb_q;
  logic        wb_ack;
  logic        link_clk;
  logic        link_ovf;
  logic        link_proto;
  logic [3:0]  tx_rate;
  logic [3:0]  rx_rate;
  logic [10:0] data_rate;
  logic        flood;
  logic        fatal;
  logic        nonfatal;
  logic [31:0] rd;
  logic [15:0] r;
  logic [15:0] s;
  logic [3:0]  code;
  logic        eo;
  logic        ep;
  logic [3:0]  prev      = 4'h0;
  logic [3:0]  sel       = 4'h3;
  logic [3:0]  wb_sel    = 4'h0;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          cycles     = 0;

  always #25 clk_i = ~clk_i;

  lfe_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .mode_i(mode), .core_clk_sel_i(core_sel), .sync_clocking_i(sync_clk),
    .warm_rst_i(warm_rst), .link_clk_i(link_clk), .link_ovf_i(link_ovf),
    .link_proto_i(link_proto), .tx_rate_o(tx_rate), .rx_rate_o(rx_rate),
    .data_rate_o(data_rate), .sync_flood_o(flood), .fatal_err_o(fatal),
    .nonfatal_err_o(nonfatal)
  );

  lfe_link_model link (
    .run_i(run), .ovf_req_i(ovf_req), .proto_req_i(proto_req),
    .link_clk_o(link_clk), .link_ovf_o(link_ovf), .link_proto_o(link_proto)
  );

  // ******************************************************************
  // Helpers
  // ******************************************************************
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  task automatic wb(input logic we, input logic [8:0] idx,
                    input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= sel;
    wb_adr <= {idx, 2'b00};
    wb_dat <= {16'h0, d};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
  endtask : wb

  task automatic strap(input logic [1:0] m, input logic [1:0] c);
    @(posedge clk_i);
    mode     <= m;
    core_sel <= c;
    idle(6);
  endtask : strap

  task automatic warm();
    @(posedge clk_i);
    warm_rst <= 1'b1;
    idle(3);
    warm_rst <= 1'b0;
    idle(10);
  endtask : warm

  task automatic pulse(input logic o, input logic p);
    @(posedge clk_i);
    ovf_req   <= o;
    proto_req <= p;
    run       <= 1'b1;
    idle(30);
    ovf_req   <= 1'b0;
    proto_req <= 1'b0;
    idle(30);
    run       <= 1'b0;
    idle(10);
  endtask : pulse

  function automatic logic [10:0] mts(input logic [3:0] c);
    mts = (c <= 4'h4) ? 11'(2 * (200 + 100 * c)) : 11'h000;
  endfunction : mts

  function automatic logic [15:0] cap(input logic [1:0] c);
    cap = (c == 2'd0) ? 16'h0007 : (c == 2'd1) ? 16'h000f : 16'h001f;
  endfunction : cap

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    void'($urandom(32'hb500_6ec2));
    idle(12);
    rst_i <= 1'b0;
    idle(6);
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    check(rd, 32'h0);
    wb(0, lfe_pkg::SCRATCH_IDX, 16'h0);
    check(rd, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      strap(2'b10, c[1:0]);
      wb(0, lfe_pkg::CAP_IDX, 16'h0);
      check(rd, {16'h0, cap(c[1:0])});
    end
    // Only defined codes are ever written
    for (int i = 0; i < 7; i++)
    begin
      code = (i < 5) ? 4'(4 - i) : 4'($urandom_range(4));
      wb(1, lfe_pkg::FREQ_ERR_IDX, {12'h000, code});
      check(tx_rate, prev);
      warm();
      check(tx_rate, code);
      check(rx_rate, code);
      check(data_rate, mts(code));
      wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
      check(rd, {28'h0, code});
      prev = code;
    end
    sync_clk <= 1'b0;
    idle(6);
    check(rx_rate, 4'h0);
    s = 16'($urandom);
    wb(1, lfe_pkg::SCRATCH_IDX, s);
    wb(0, lfe_pkg::SCRATCH_IDX, 16'h0);
    check(rd, {16'h0, s});
    check(data_rate, mts(code));
    sel = 4'h2;
    wb(1, lfe_pkg::SCRATCH_IDX, ~s);
    sel = 4'h3;
    wb(0, lfe_pkg::SCRATCH_IDX, 16'h0);
    s = {~s[15:8], s[7:0]};
    check(rd, {16'h0, s});
    for (int i = 1; i < 4; i++)
    begin
      r = (i == 3) ? lfe_pkg::ROUTE_MASK
                   : 16'($urandom) & lfe_pkg::ROUTE_MASK;
      eo = i[0];
      ep = i[1];
      wb(1, lfe_pkg::ROUTE_IDX, r);
      pulse(eo, ep);
      check({flood, fatal, nonfatal}, {eo & r[1] | ep & r[0],
            eo & r[3] | ep & r[2], eo & r[11] | ep & r[10]});
      wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
      check(rd[5:4], {eo, ep});
      wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
      check(rd[5:4], 2'b00);
      check({flood, fatal, nonfatal}, 3'b000);
    end
    // Clearing reads collide with protocol events
    proto_req <= 1'b1;
    run       <= 1'b1;
    ep = 1'b0;
    repeat (10)
    begin
      wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
      ep = ep | rd[4];
    end
    check(ep, 1'b1);
    pulse(0, 0);
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    check(rd[5:4], 2'b00);
    pulse(1, 1);
    warm();
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    check(rd, {26'h0, 2'b11, code});
    wb(0, lfe_pkg::ROUTE_IDX, 16'h0);
    check(rd, 32'h0);
    wb(0, lfe_pkg::SCRATCH_IDX, 16'h0);
    check(rd, {16'h0, s});
    for (int m = 0; m < 2; m++)
    begin
      strap(m[1:0], 2'b10);
      pulse(1, 0);
      wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
      check(rd, 32'h0);
      wb(0, lfe_pkg::CAP_IDX, 16'h0);
      check(rd, 32'h0);
      wb(0, lfe_pkg::SCRATCH_IDX, 16'h0);
      check(rd, 32'h0);
    end
    strap(2'b11, 2'b01);
    wb(1, lfe_pkg::SEC_FREQ_ERR_IDX, 16'h0003);
    wb(0, lfe_pkg::SEC_FREQ_ERR_IDX, 16'h0);
    check(rd[3:0], 4'h3);
    wb(0, lfe_pkg::SEC_CAP_IDX, 16'h0);
    check(rd, 32'h0000_000f);
    wb(0, lfe_pkg::STATUS_IDX, 16'h0);
    check(rd, {24'h0, 2'b01, 2'b11, code});
    warm();
    check(tx_rate, 4'h3);
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    check(rd, 32'h0);
    wb(0, 9'h1ff, 16'h0);
    check(rd, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    idle(3);
    rst_i <= 1'b0;
    strap(2'b10, 2'b10);
    wb(0, lfe_pkg::FREQ_ERR_IDX, 16'h0);
    check(rd, 32'h0);
    check(tx_rate, 4'h0);
    close_out();
  end
endmodule : tb
